/* File: hw/ssi_reader_pkg.sv */
/*
 * Shared constants for the serial position encoder reader.
 * Assumes a 20 MHz core clock and an 80 ns period link clock.
 */
package ssi_reader_pkg;
	localparam int CORE_CLK_HZ = 20000000;
	localparam int LINK_CLK_HZ = 12500000;
	localparam int DEFAULT_RATE_HZ = 250000;
	localparam int MAX_RATE_HZ = 1000000;
	// half periods of the encoder clock, in link clock cycles
	localparam int DEFAULT_HALF_CYCLES = LINK_CLK_HZ / (2 * DEFAULT_RATE_HZ);
	localparam int MIN_HALF_CYCLES = (LINK_CLK_HZ + 2 * MAX_RATE_HZ - 1) / (2 * MAX_RATE_HZ);
	localparam int HALF_W = 8;
	localparam logic [HALF_W-1:0] HALF_RESET = 8'(DEFAULT_HALF_CYCLES);
	localparam logic [HALF_W-1:0] HALF_MIN = 8'(MIN_HALF_CYCLES);
	// idle pause between bursts, in microseconds, and its cycle count
	localparam int PAUSE_US = 30;
	// multiply first: the link clock is not a whole number of MHz
	localparam int PAUSE_CYCLES = (PAUSE_US * LINK_CLK_HZ) / 1000000;
	localparam int PAUSE_W = 10;
	localparam int WORD_W = 32;
	localparam int COUNT_W = 6;
	localparam logic [COUNT_W-1:0] BITS_RESET = 6'h18;
	localparam logic [COUNT_W-1:0] BITS_MAX = 6'h20;
	localparam logic [COUNT_W-1:0] BITS_MIN = 6'h01;
	typedef enum logic [2:0]
	{
		LINK_IDLE = 3'b001,
		LINK_LOW = 3'b010,
		LINK_HIGH = 3'b100
	} link_state_t;
endpackage

/* File: hw/ssi_word_if.sv */
/*
 * Carries one finished frame from the link domain to the core domain.
 * Assumes a toggle handshake: data is stable while done_tgl differs from the copy held.
 */
`timescale 1ns/1ps
`default_nettype none
interface ssi_word_if;
	import ssi_reader_pkg::*;
	logic [WORD_W-1:0] word;
	logic [COUNT_W-1:0] nbits;
	logic done_tgl;
	logic busy;
	modport link
	(
		output word,
		output nbits,
		output done_tgl,
		output busy
	);
	modport core
	(
		input word,
		input nbits,
		input done_tgl,
		input busy
	);
endinterface
`default_nettype wire

/* File: hw/ssi_link_engine.sv */
/*
 * Link side: clock bursts, bit capture and pause timing on the link clock.
 * Assumes configuration inputs are quasi-static and held in the link domain already.
 */
`timescale 1ns/1ps
`default_nettype none
module ssi_link_engine
	import ssi_reader_pkg::*;
(
	// link clock and reset
	input wire logic link_clk_in,
	input wire logic rst_b_in,
	// configuration, already synchronised
	input wire logic [COUNT_W-1:0] bits_in,
	input wire logic [HALF_W-1:0] half_in,
	// encoder pins
	input wire logic enc_data_in,
	output logic enc_clk_out,
	// frame hand-off
	ssi_word_if.link word_port
);
	import ssi_reader_pkg::*;

	logic data_meta;
	logic data_sync;
	link_state_t state;
	link_state_t next_state;
	logic [HALF_W-1:0] half_cnt;
	logic [HALF_W-1:0] next_half_cnt;
	logic [PAUSE_W-1:0] pause_cnt;
	logic [PAUSE_W-1:0] next_pause_cnt;
	logic [COUNT_W-1:0] bit_cnt;
	logic [COUNT_W-1:0] next_bit_cnt;
	logic [WORD_W-1:0] shift;
	logic [WORD_W-1:0] next_shift;
	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] next_word;
	logic [COUNT_W-1:0] nbits;
	logic [COUNT_W-1:0] next_nbits;
	logic done_tgl;
	logic next_done_tgl;
	logic clk_q;
	logic next_clk_q;
	logic in_burst;
	logic next_in_burst;

	always_ff @(posedge link_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			data_meta <= 1'b0;
			data_sync <= 1'b0;
		end
		else
		begin
			data_meta <= enc_data_in;
			data_sync <= data_meta;
		end
	end

	always_comb
	begin
		next_state = state;
		next_half_cnt = half_cnt;
		next_pause_cnt = pause_cnt;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_word = word;
		next_nbits = nbits;
		next_done_tgl = done_tgl;
		next_clk_q = clk_q;
		unique case (state)
			LINK_IDLE:
			begin
				next_clk_q = 1'b1;
				if (pause_cnt != '0)
				begin
					next_pause_cnt = pause_cnt - 1'b1;
				end
				else
				begin
					// first falling edge: encoder latches its position here
					next_state = LINK_LOW;
					next_clk_q = 1'b0;
					next_half_cnt = half_in;
					next_bit_cnt = bits_in;
					next_nbits = bits_in;
					next_shift = '0;
				end
			end
			LINK_LOW:
			begin
				if (half_cnt > 8'h01)
				begin
					next_half_cnt = half_cnt - 1'b1;
				end
				else
				begin
					next_state = LINK_HIGH;
					next_clk_q = 1'b1;
					next_half_cnt = half_in;
				end
			end
			LINK_HIGH:
			begin
				if (half_cnt > 8'h01)
				begin
					next_half_cnt = half_cnt - 1'b1;
				end
				else
				begin
					// sample late in the high phase to cover cable and sync delay
					next_shift = {shift[WORD_W-2:0], data_sync};
					next_bit_cnt = bit_cnt - 1'b1;
					if (bit_cnt == BITS_MIN)
					begin
						next_state = LINK_IDLE;
						next_word = {shift[WORD_W-2:0], data_sync};
						next_done_tgl = ~done_tgl;
						next_pause_cnt = PAUSE_W'(PAUSE_CYCLES);
					end
					else
					begin
						next_state = LINK_LOW;
						next_clk_q = 1'b0;
						next_half_cnt = half_in;
					end
				end
			end
		endcase
		// registered so the core side never syncs a decode glitch
		next_in_burst = (next_state != LINK_IDLE);
	end

	always_ff @(posedge link_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state <= LINK_IDLE;
			half_cnt <= HALF_RESET;
			pause_cnt <= PAUSE_W'(PAUSE_CYCLES);
			bit_cnt <= BITS_RESET;
			shift <= '0;
			word <= '0;
			nbits <= BITS_RESET;
			done_tgl <= 1'b0;
			clk_q <= 1'b1;
			in_burst <= 1'b0;
		end
		else
		begin
			state <= next_state;
			half_cnt <= next_half_cnt;
			pause_cnt <= next_pause_cnt;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			word <= next_word;
			nbits <= next_nbits;
			done_tgl <= next_done_tgl;
			clk_q <= next_clk_q;
			in_burst <= next_in_burst;
		end
	end

	assign enc_clk_out = clk_q;
	assign word_port.word = word;
	assign word_port.nbits = nbits;
	assign word_port.done_tgl = done_tgl;
	assign word_port.busy = in_burst;
endmodule // ssi_link_engine
`default_nettype wire

/* File: hw/ssi_encoder_reader.sv */
/*
 * Top of the serial position encoder reader: configuration, domain crossing,
 * Gray decoding and the four input bytes for the process image.
 * Assumes the encoder clock line idles high and the encoder answers on the data line.
 */
// Summary of operation
// - each read is a burst of clock pulses of constant period on the encoder clock output.
// - clocking stops once the configured number of bits has been shifted in.
// - after each burst an idle pause passes, then polling repeats without end.
// - one bit moves per clock period, so bit rate equals clock rate.
// - after reset a frame carries 24 data bits.
// - when cfg_gray_in is set, the Gray coded word is converted to binary for the alternative format.
// - the encoder clock defaults to 250 kHz.
// - in the alternative format the position fills the four input bytes, lowest first.
// - in the standard format, the reset state, four input bytes go to the process image.
// - the clock rate is configurable up to about 893 kHz (half period of 7 link cycles) with 250 kHz preset.
`timescale 1ns/1ps
`default_nettype none
module ssi_encoder_reader
(
	// core clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// link clock for the encoder side
	input wire logic link_clk_in,
	// configuration, quasi-static
	input wire logic [ssi_reader_pkg::COUNT_W-1:0] cfg_bits_in,
	input wire logic [ssi_reader_pkg::HALF_W-1:0] cfg_half_in,
	input wire logic cfg_alt_format_in,
	input wire logic cfg_gray_in,
	input wire logic cfg_flag_last_in,
	// encoder pins
	input wire logic enc_data_in,
	output logic enc_clk_out,
	// process image
	output logic [7:0] position_input_bytes_out [4],
	output logic supply_loss_flag_out,
	output logic frame_valid_out,
	output logic link_busy_out
);
	import ssi_reader_pkg::*;

	ssi_word_if word_bus ();

	// ***********************************************
	// configuration into the link domain
	// ***********************************************
	logic [COUNT_W-1:0] bits_meta;
	logic [COUNT_W-1:0] bits_sync;
	logic [HALF_W-1:0] half_meta;
	logic [HALF_W-1:0] half_sync;
	logic [COUNT_W-1:0] bits_safe;
	logic [HALF_W-1:0] half_safe;

	// quasi-static settings; a change mid-burst may give one odd frame
	always_ff @(posedge link_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			bits_meta <= BITS_RESET;
			bits_sync <= BITS_RESET;
			half_meta <= HALF_RESET;
			half_sync <= HALF_RESET;
		end
		else
		begin
			bits_meta <= cfg_bits_in;
			bits_sync <= bits_meta;
			half_meta <= cfg_half_in;
			half_sync <= half_meta;
		end
	end

	always_comb
	begin
		bits_safe = bits_sync;
		if (bits_sync < BITS_MIN || bits_sync > BITS_MAX)
		begin
			bits_safe = BITS_RESET;
		end
		half_safe = half_sync;
		if (half_sync < HALF_MIN)
		begin
			half_safe = HALF_MIN;
		end
	end

	ssi_link_engine link_engine
	(
		.link_clk_in(link_clk_in),
		.rst_b_in(rst_b_in),
		.bits_in(bits_safe),
		.half_in(half_safe),
		.enc_data_in(enc_data_in),
		.enc_clk_out(enc_clk_out),
		.word_port(word_bus.link)
	);

	// ***********************************************
	// frame crossing into the core domain
	// ***********************************************
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;
	logic busy_meta;
	logic busy_sync;
	logic take;

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
			tgl_seen <= 1'b0;
			busy_meta <= 1'b0;
			busy_sync <= 1'b0;
		end
		else
		begin
			tgl_meta <= word_bus.done_tgl;
			tgl_sync <= tgl_meta;
			tgl_seen <= tgl_sync;
			busy_meta <= word_bus.busy;
			busy_sync <= busy_meta;
		end
	end

	// busy is a status level only; a late edge costs nothing
	// word is held for a full pause after each toggle, so it is stable here
	assign take = tgl_sync ^ tgl_seen;

	// ***********************************************
	// decoding and output bytes
	// ***********************************************
	logic [WORD_W-1:0] raw;
	logic [WORD_W-1:0] pos_bits;
	logic [WORD_W-1:0] binary;
	logic flag_bit;
	logic [WORD_W-1:0] result;
	logic [7:0] next_bytes [4];
	logic next_flag;
	logic next_valid;
	logic next_busy;

	always_comb
	begin
		raw = word_bus.word;
		flag_bit = 1'b0;
		pos_bits = raw;
		if (cfg_flag_last_in)
		begin
			flag_bit = raw[0];
			pos_bits = raw >> 1;
		end
		// the chain starts at bit WORD_W-1, whatever the configured frame length
		binary = '0;
		for (int i = WORD_W - 1; i >= 0; i--)
		begin
			if (i == WORD_W - 1)
			begin
				binary[i] = pos_bits[i];
			end
			else
			begin
				binary[i] = binary[i + 1] ^ pos_bits[i];
			end
		end
		// leading zeros of a right-aligned word leave the xor chain unaffected
		result = pos_bits;
		if (cfg_alt_format_in && cfg_gray_in)
		begin
			result = binary;
		end
		// hold the image between frames
		next_flag = supply_loss_flag_out;
		next_valid = frame_valid_out;
		for (int b = 0; b < 4; b++)
		begin
			next_bytes[b] = position_input_bytes_out[b];
			if (take)
			begin
				next_bytes[b] = result[8*b +: 8];
			end
		end
		if (take)
		begin
			next_flag = flag_bit;
			next_valid = 1'b1;
		end
		next_busy = busy_sync;
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			for (int b = 0; b < 4; b++)
			begin
				position_input_bytes_out[b] <= 8'h00;
			end
			supply_loss_flag_out <= 1'b0;
			frame_valid_out <= 1'b0;
			link_busy_out <= 1'b0;
		end
		else
		begin
			for (int b = 0; b < 4; b++)
			begin
				position_input_bytes_out[b] <= next_bytes[b];
			end
			supply_loss_flag_out <= next_flag;
			frame_valid_out <= next_valid;
			link_busy_out <= next_busy;
		end
	end
endmodule // ssi_encoder_reader
`default_nettype wire

/* File: verification/ssi_encoder_model.sv */
/* behavioural absolute encoder on the clock and data pins
   assumes the clock idles high and the bench sets the word and length */
`timescale 1ns/1ps
`default_nettype none
module ssi_encoder_model
(
	// pins
	input wire logic enc_clk_in,
	output logic enc_data_out,
	// bench control
	input wire logic [31:0] pos_in,
	input wire logic [5:0] len_in
);
	logic [31:0] word;
	int idx;
	initial
	begin
		enc_data_out = 1'b1;
		word = 32'h0;
		idx = 0;
	end
	always @(enc_clk_in)
	begin
		if (!enc_clk_in && idx == 0)
		begin
			word = pos_in;
			idx = int'(len_in);
		end
		else if (enc_clk_in && idx > 0)
		begin
			idx = idx - 1;
			enc_data_out <= word[idx];
			// line floats back high once the hold time runs out
			if (idx == 0)
				enc_data_out <= #5000 1'b1;
		end
	end
endmodule // ssi_encoder_model
`default_nettype wire

/* File: verification/ssi_encoder_reader_monitor.sv */
/* pin monitor of the encoder reader
   assumes binding onto ssi_encoder_reader */
`timescale 1ns/1ps
`default_nettype none
module ssi_encoder_reader_monitor
(
	// clocks and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic link_clk_in,
	// configuration
	input wire logic [ssi_reader_pkg::COUNT_W-1:0] cfg_bits_in,
	input wire logic [ssi_reader_pkg::HALF_W-1:0] cfg_half_in,
	input wire logic cfg_alt_format_in,
	input wire logic cfg_gray_in,
	input wire logic cfg_flag_last_in,
	// pins and image
	input wire logic enc_data_in,
	input wire logic enc_clk_out,
	input wire logic [7:0] position_input_bytes_out [4],
	input wire logic supply_loss_flag_out,
	input wire logic frame_valid_out,
	input wire logic link_busy_out
);
	import ssi_reader_pkg::*;
	// ****
	// run lengths of the encoder clock
	// ****
	logic [9:0] hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;
	logic [5:0] falls, next_falls, bits_eff;
	logic [7:0] half_eff;
	logic [7:0] half_prev, next_half_prev;
	always_comb
	begin
		half_eff = (cfg_half_in < HALF_MIN) ? HALF_MIN : cfg_half_in;
		bits_eff = (cfg_bits_in == 6'h00 || cfg_bits_in > BITS_MAX) ? BITS_RESET : cfg_bits_in;
		next_hi_cnt = enc_clk_out ? hi_cnt + 10'h001 : 10'h000;
		next_lo_cnt = enc_clk_out ? 10'h000 : lo_cnt + 10'h001;
		next_falls = falls;
		next_half_prev = half_prev;
		// a long high run before a fall means a new burst
		if (!enc_clk_out && hi_cnt != 10'h000)
		begin
			next_falls = (hi_cnt > 10'(half_eff)) ? 6'h01 : falls + 6'h01;
			// half length of the burst in progress, kept through the pause
			next_half_prev = half_eff;
		end
	end
	always_ff @(posedge link_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			hi_cnt <= 10'h000;
			lo_cnt <= 10'h000;
			falls <= 6'h00;
			half_prev <= 8'h00;
		end
		else
		begin
			hi_cnt <= next_hi_cnt;
			lo_cnt <= next_lo_cnt;
			falls <= next_falls;
			half_prev <= next_half_prev;
		end
	end
	// ****
	// properties
	// ****
	a_low_width:
	assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
		$rose(enc_clk_out) |-> lo_cnt == 10'(half_eff)) else $error("low half length");
	a_high_width:
	assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
		$fell(enc_clk_out) |-> hi_cnt == 10'(half_eff)
		|| hi_cnt == 10'(half_prev) + 10'(PAUSE_CYCLES + 1)) else $error("high run length");
	a_bit_count:
	assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
		hi_cnt == 10'(half_prev) + 10'h001 && falls != 6'h00 |-> falls == bits_eff)
		else $error("pulse count");
	a_busy_rise:
	assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
		$fell(enc_clk_out) |-> ##[0:4] link_busy_out) else $error("busy missing");
	a_busy_end:
	assert property (@(posedge link_clk_in) disable iff (!rst_b_in)
		hi_cnt == 10'(half_prev) + 10'h028 |-> !link_busy_out) else $error("busy in pause");
	a_valid_sticky:
	assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		frame_valid_out |=> frame_valid_out) else $error("valid dropped");
	a_empty_image:
	assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		!frame_valid_out |-> {position_input_bytes_out[3], position_input_bytes_out[2],
		position_input_bytes_out[1], position_input_bytes_out[0]} == 32'h0)
		else $error("image before frame");
	a_top_byte_zero:
	assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		frame_valid_out && cfg_bits_in <= 6'h18 && !link_busy_out
		|-> position_input_bytes_out[3] == 8'h00) else $error("top byte set");
endmodule // ssi_encoder_reader_monitor
bind ssi_encoder_reader ssi_encoder_reader_monitor i_mon
(
	.core_clk_in,
	.rst_b_in,
	.link_clk_in,
	.cfg_bits_in,
	.cfg_half_in,
	.cfg_alt_format_in,
	.cfg_gray_in,
	.cfg_flag_last_in,
	.enc_data_in,
	.enc_clk_out,
	.position_input_bytes_out,
	.supply_loss_flag_out,
	.frame_valid_out,
	.link_busy_out
);
`default_nettype wire

/* File: verification/ssi_encoder_reader_tb.sv */
/* self-checking bench of the encoder reader
   assumes the encoder model and the monitor are compiled first */
`timescale 1ns/1ps
`default_nettype none
module ssi_encoder_reader_tb;
	import ssi_reader_pkg::*;
	logic core_clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0;
	logic [5:0] bits = 6'h18, len = 6'h18;
	logic [7:0] half = 8'h19;
	logic alt = 1'b0, gray = 1'b0, flag = 1'b0;
	logic enc_data, enc_clk, loss, valid, busy;
	logic [7:0] img [4];
	logic [31:0] pos = 32'h0, seed = 32'hF571CA20;
	// {bits, half, alt gray flag}; out of range widths fall back to 24
	logic [16:0] tbl [7] = '{{6'h18, 8'h19, 3'h0}, {6'h18, 8'h19, 3'h6}, {6'h19, 8'h07, 3'h7},
		{6'h0D, 8'h03, 3'h4}, {6'h2A, 8'h19, 3'h0}, {6'h01, 8'h0A, 3'h5}, {6'h20, 8'h07, 3'h6}};
	int fails = 0, cmp_count = 0, cycles = 0;
	always #25 core_clk = ~core_clk;
	always #40 link_clk = ~link_clk;
	ssi_encoder_reader i_dut
	(
		.core_clk_in(core_clk),
		.rst_b_in(rst_b),
		.link_clk_in(link_clk),
		.cfg_bits_in(bits),
		.cfg_half_in(half),
		.cfg_alt_format_in(alt),
		.cfg_gray_in(gray),
		.cfg_flag_last_in(flag),
		.enc_data_in(enc_data),
		.enc_clk_out(enc_clk),
		.position_input_bytes_out(img),
		.supply_loss_flag_out(loss),
		.frame_valid_out(valid),
		.link_busy_out(busy)
	);
	ssi_encoder_model i_enc
	(
		.enc_clk_in(enc_clk),
		.enc_data_out(enc_data),
		.pos_in(pos),
		.len_in(len)
	);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("fails=%0d compares=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 4000)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n == 4000)
			fails++;
	endtask
	// one frame under one setting, checked against the reference
	task automatic run(input logic [16:0] e);
		int n;
		logic [31:0] raw, v;
		wait_busy(1'b0);
		// settle past the end of the last burst before reconfiguring
		repeat (60) @(negedge core_clk);
		bits = e[16:11];
		half = e[10:3];
		{alt, gray, flag} = e[2:0];
		n = (bits == 6'h00 || bits > 6'h20) ? 24 : int'(bits);
		len = 6'(n);
		seed = xs(seed);
		pos = seed;
		raw = (n == 32) ? seed : seed & ((32'h1 << n) - 32'h1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		repeat (8) @(negedge core_clk);
		v = flag ? raw >> 1 : raw;
		if (alt && gray)
			for (int i = 30; i >= 0; i--)
				v[i] = v[i] ^ v[i + 1];
		chk({img[3], img[2], img[1], img[0]}, v);
		chk({31'h0, valid}, 32'h1);
		if (flag)
			chk({31'h0, loss}, {31'h0, raw[0]});
		else
			chk({31'h0, loss}, 32'h0);
	endtask
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			fails++;
			summarize();
		end
	end
	initial
	begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk({31'h0, enc_clk}, 32'h1);
		chk({31'h0, valid}, 32'h0);
		rst_b = 1'b1;
		for (int k = 0; k < 14; k++)
			run(tbl[k / 2]);
		summarize();
	end
endmodule // ssi_encoder_reader_tb
`default_nettype wire
